// [common/jtp_pkg.sv]
/*
 Shared types and constants of the test access port block.
 Assumes a SystemVerilog tool; no timescale in packages.
*/
package jtp_pkg;
  localparam int IR_WIDTH = 3;
  localparam int BSR_WIDTH = 8;
  localparam int RESET_TMS_EDGES = 5;
  localparam logic [2:0] IR_CAPTURE_VAL = 3'h4;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_SAMPLE = 3'h2;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [31:0] IDCODE_VAL = 32'h00000001;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
    ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } jtp_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtp_link_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } jtp_link_out_t;
endpackage

// [hdl/jtp_sync.sv]
/*
 Two-stage level synchroniser.
 Assumes asynchronous input and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module jtp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } jtp_sync_st_t;
  jtp_sync_st_t st_reg;
  jtp_sync_st_t st_next;

  initial begin
    if (WIDTH < 1) $error("WIDTH must be positive");
  end

  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule

// [hdl/jtp_tap.sv]
/*
 Test access port: sixteen-state controller, instruction register,
 identification, bypass and boundary-scan data registers.
 Assumes the test master drives the link pins on the link clock; core
 pins and the sys_rst reset live in the clk domain.
*/
// Summary of operation
// - Sixteen states, moves decided by sampled mode-select
// - Five high mode-select edges force reset state
// - Reset state: test logic off, identify instruction
// - Idle holds while low, high goes select-DR
// - Select-DR: low captures, high goes select-IR
// - Boundary capture only for extest or sample
// - Capture-DR: high exit1, low shift
// - Shift-DR shifts data toward output per edge
// - Exit1-DR: high update, low pause
// - Pause-DR holds contents, high goes exit2
// - Exit2-DR: high update, low back to shift
// - Boundary output latched on falling update edge, only for extest or sample
// - Select-IR: low captures, high goes reset
// - Capture-IR loads fixed pattern one-zero-zero
// - Capture-IR: high exit1, low shift
// - Instruction unchanged outside update-IR and reset states
// - Shift-IR shifts instruction, high goes exit1
// - Exit1-IR: high update, low pause
// - Pause-IR and exit2-IR move like data path
// - Instruction latched on falling update-IR edge
`timescale 1ns/100ps
module jtp_tap
  import jtp_pkg::*;
#(
  parameter int BSR_LEN = jtp_pkg::BSR_WIDTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tck_rst,
  input wire logic tms,
  input wire logic tdi,
  output jtp_pkg::jtp_link_out_t link_out,
  input wire logic [BSR_LEN-1:0] core_pins_in,
  output logic [BSR_LEN-1:0] bsr_pins_out,
  output logic test_mode
);
  import jtp_pkg::*;

  initial begin
    if (BSR_LEN < 1) $error("BSR_LEN must be positive");
  end

  // Link-domain rising edge state
  typedef struct packed {
    jtp_state_t state;
    logic [IR_WIDTH-1:0] ir_shift;
    logic [31:0] id_shift;
    logic byp;
    logic [BSR_LEN-1:0] bsr_shift;
    logic tdo;
    logic tdo_oe;
    logic [2:0] hi_cnt;
  } jtp_rise_t;

  // Link-domain falling edge state
  typedef struct packed {
    logic [IR_WIDTH-1:0] ir;
    logic [BSR_LEN-1:0] bsr_out;
    logic ext;
    logic upd_tgl;
  } jtp_fall_t;

  // Core-domain state
  typedef struct packed {
    logic [BSR_LEN-1:0] pins;
    logic test_mode;
    logic tgl_seen;
  } jtp_core_t;

  jtp_rise_t r_reg;
  jtp_rise_t r_next;
  jtp_fall_t f_reg;
  jtp_fall_t f_next;
  jtp_core_t c_reg;
  jtp_core_t c_next;
  logic [BSR_LEN-1:0] pins_sync;
  logic [1:0] to_core;
  logic [1:0] to_core_sync;
  logic sel_bsr;
  logic tdo_src;

  // Core pins are not related to the link clock
  jtp_sync #(.WIDTH(BSR_LEN)) u_pin_sync (
    .clk(tck),
    .sys_rst(tck_rst),
    .d(core_pins_in),
    .q(pins_sync)
  );

  always_comb begin
    sel_bsr = (f_reg.ir == INS_EXTEST) || (f_reg.ir == INS_SAMPLE);
  end

  always_comb begin
    r_next = r_reg;
    tdo_src = r_reg.byp;
    unique case (r_reg.state)
      ST_RESET: r_next.state = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: r_next.state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: r_next.state = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: r_next.state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: r_next.state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: r_next.state = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: r_next.state = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: r_next.state = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: r_next.state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: r_next.state = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: r_next.state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: r_next.state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: r_next.state = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: r_next.state = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: r_next.state = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: r_next.state = tms ? ST_SEL_DR : ST_IDLE;
    endcase
    // Count of high mode-select edges, saturating
    r_next.hi_cnt = tms ? r_reg.hi_cnt + 3'h1 : 3'h0;
    if (tms && r_reg.hi_cnt == 3'h7) begin
      r_next.hi_cnt = 3'h7;
    end
    // Data registers move only in capture and shift; elsewhere held
    if (r_reg.state == ST_CAP_DR) begin
      if (sel_bsr) begin
        r_next.bsr_shift = pins_sync;
      end
      r_next.id_shift = IDCODE_VAL;
      r_next.byp = 1'b0;
    end
    if (r_reg.state == ST_SH_DR) begin
      unique case (f_reg.ir)
        INS_EXTEST, INS_SAMPLE: begin
          tdo_src = r_reg.bsr_shift[0];
          r_next.bsr_shift = {tdi, r_reg.bsr_shift[BSR_LEN-1:1]};
        end
        INS_IDCODE: begin
          tdo_src = r_reg.id_shift[0];
          r_next.id_shift = {tdi, r_reg.id_shift[31:1]};
        end
        default: begin
          tdo_src = r_reg.byp;
          r_next.byp = tdi;
        end
      endcase
    end
    if (r_reg.state == ST_CAP_IR) begin
      r_next.ir_shift = IR_CAPTURE_VAL;
    end
    if (r_reg.state == ST_SH_IR) begin
      tdo_src = r_reg.ir_shift[0];
      r_next.ir_shift = {tdi, r_reg.ir_shift[IR_WIDTH-1:1]};
    end
    // Output changes on the rising edge here; the master samples after the falling edge
    r_next.tdo = (r_reg.state == ST_SH_DR || r_reg.state == ST_SH_IR)
      ? tdo_src : 1'b0;
    r_next.tdo_oe = (r_next.state == ST_SH_DR) ||
      (r_next.state == ST_SH_IR);
  end

  always_ff @(posedge tck) begin
    if (tck_rst) begin
      r_reg <= '0;
      r_reg.state <= ST_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  always_comb begin
    f_next = f_reg;
    if (r_reg.state == ST_RESET) begin
      f_next.ir = INS_IDCODE;
    end else if (r_reg.state == ST_UPD_IR) begin
      f_next.ir = r_reg.ir_shift;
    end
    if (r_reg.state == ST_UPD_DR && sel_bsr) begin
      f_next.bsr_out = r_reg.bsr_shift;
      f_next.upd_tgl = ~f_reg.upd_tgl;
    end
    f_next.ext = (f_next.ir == INS_EXTEST);
  end

  always_ff @(negedge tck) begin
    if (tck_rst) begin
      f_reg <= '0;
      f_reg.ir <= INS_IDCODE;
    end else begin
      f_reg <= f_next;
    end
  end

  // Flag and update toggle cross to clk; the word follows the toggle
  assign to_core = {f_reg.ext, f_reg.upd_tgl};

  // Toggle handshake keeps a half-written word from reaching the pins
  jtp_sync #(.WIDTH(2)) u_core_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(to_core),
    .q(to_core_sync)
  );

  always_comb begin
    c_next = c_reg;
    c_next.test_mode = to_core_sync[1];
    c_next.tgl_seen = to_core_sync[0];
    // Word is settled well before its toggle arrives here
    if (to_core_sync[0] != c_reg.tgl_seen) begin
      c_next.pins = f_reg.bsr_out;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  assign bsr_pins_out = c_reg.pins;
  assign test_mode = c_reg.test_mode;
  assign link_out.tdo = r_reg.tdo;
  assign link_out.tdo_oe = r_reg.tdo_oe;

  chk_forced_reset: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.hi_cnt >= 3'(RESET_TMS_EDGES) |-> r_reg.state == ST_RESET)
    else $error("not in reset after five high edges");
  chk_idle_hold: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_IDLE && !tms |=> r_reg.state == ST_IDLE)
    else $error("idle left with mode-select low");
  chk_ir_capture: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_CAP_IR |=> r_reg.ir_shift == IR_CAPTURE_VAL)
    else $error("capture-IR pattern wrong");
  chk_dr_exit: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_EX1_DR && tms |=> r_reg.state == ST_UPD_DR)
    else $error("exit1-DR did not go to update");
  chk_sel_ir: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_SEL_IR && tms |=> r_reg.state == ST_RESET)
    else $error("select-IR did not return to reset");
  chk_pause_hold: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_PAU_DR |=> $stable(r_reg.bsr_shift))
    else $error("boundary shift moved during pause");
  chk_ir_stable: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state inside {ST_SH_IR, ST_CAP_IR, ST_PAU_IR}
    |=> $stable(f_reg.ir))
    else $error("instruction changed outside update");
  chk_tdo_enable: assert property (@(posedge tck) disable iff (tck_rst)
    link_out.tdo_oe |-> r_reg.state inside {ST_SH_DR, ST_SH_IR})
    else $error("output enabled outside shift");
  chk_reset_hold: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_RESET && tms |=> r_reg.state == ST_RESET)
    else $error("reset state left with mode-select high");
  chk_reset_leave: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_RESET && !tms |=> r_reg.state == ST_IDLE)
    else $error("reset state did not go to idle");
  chk_ir_reset: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_RESET |-> f_reg.ir == INS_IDCODE)
    else $error("instruction not identify in reset");
  chk_idle_go: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_IDLE && tms |=> r_reg.state == ST_SEL_DR)
    else $error("idle did not go to select-DR");
  chk_sel_dr: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_SEL_DR && !tms |=> r_reg.state == ST_CAP_DR)
    else $error("select-DR did not capture");
  chk_bsr_capture: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_CAP_DR && sel_bsr
    |=> r_reg.bsr_shift == $past(pins_sync))
    else $error("boundary capture wrong");
  chk_cap_dr: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_CAP_DR && !tms |=> r_reg.state == ST_SH_DR)
    else $error("capture-DR did not go to shift");
  chk_shift_dr: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_SH_DR && tms |=> r_reg.state == ST_EX1_DR)
    else $error("shift-DR did not exit");
  chk_ex1_pause: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_EX1_DR && !tms |=> r_reg.state == ST_PAU_DR)
    else $error("exit1-DR did not pause");
  chk_pause_exit: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_PAU_DR && tms |=> r_reg.state == ST_EX2_DR)
    else $error("pause-DR did not go to exit2");
  chk_ex2_dr: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_EX2_DR && !tms |=> r_reg.state == ST_SH_DR)
    else $error("exit2-DR did not resume shift");
  chk_ex2_upd: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_EX2_DR && tms |=> r_reg.state == ST_UPD_DR)
    else $error("exit2-DR did not update");
  chk_bsr_latch: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state != ST_UPD_DR |-> $stable(f_reg.bsr_out))
    else $error("boundary output changed outside update");
  chk_sel_ir_cap: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_SEL_IR && !tms |=> r_reg.state == ST_CAP_IR)
    else $error("select-IR did not capture");
  chk_cap_ir_go: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_CAP_IR && tms |=> r_reg.state == ST_EX1_IR)
    else $error("capture-IR did not exit");
  chk_shift_ir: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_SH_IR && tms |=> r_reg.state == ST_EX1_IR)
    else $error("shift-IR did not exit");
  chk_ex1_ir: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_EX1_IR && !tms |=> r_reg.state == ST_PAU_IR)
    else $error("exit1-IR did not pause");
  chk_pause_ir: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_PAU_IR && tms |=> r_reg.state == ST_EX2_IR)
    else $error("pause-IR did not go to exit2");
  chk_ex2_ir: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_EX2_IR && !tms |=> r_reg.state == ST_SH_IR)
    else $error("exit2-IR did not resume shift");
  chk_ir_update: assert property (@(posedge tck) disable iff (tck_rst)
    r_reg.state == ST_UPD_IR |-> f_reg.ir == r_reg.ir_shift)
    else $error("instruction not latched in update");
endmodule

// [sim/jtp_master.sv]
/*
 Test master model: drives the link and clocks it only inside frames.
 Assumes the tap samples tms and tdi on rising tck, tdo one edge late.
*/
`timescale 1ns/100ps
module jtp_master (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic q;
  logic qe;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Stale tdi is inverted so a late sample never passes by luck
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    #62.5 tck = 1'b0;
    q = tdo;
    qe = tdo_oe;
    tdi = ~d;
  endtask
  task automatic reset_tap();
    repeat (5) step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  // Idle to idle; one spare shift edge since tdo lags by one edge
  task automatic scan(input bit ir, input int n, input int pz,
      input logic [31:0] din, output logic [31:0] dout, output logic oe);
    logic [32:0] dx;
    dx = {din, 1'b0};
    dout = '0;
    oe = 1'b1;
    step(1'b1, 1'b0);
    if (ir) step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int k = 0; k <= n; k++) begin
      step(k == n || k == pz, dx[k]);
      if (k < n && k < pz) begin
        dout[k] = q;
        oe &= qe;
      end
      if (k == pz) begin
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        oe &= ~qe;
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
      end
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
endmodule

// [sim/tb.sv]
/*
 Self-checking bench of the test access port.
 Assumes the master model owns the link; core pins driven off clk.
*/
`timescale 1ns/100ps
module tb;
  import jtp_pkg::*;
  logic clk;
  logic sys_rst;
  logic tck_rst;
  logic tck;
  logic tms;
  logic tdi;
  logic test_mode;
  logic oe;
  logic [7:0] pins_in;
  logic [7:0] pins_out;
  logic [31:0] got;
  jtp_link_out_t link_out;
  int n_fail;
  int samples_checked;
  int cycles;

  jtp_tap #(.BSR_LEN(8)) uut (
    .clk(clk),
    .sys_rst(sys_rst),
    .tck(tck),
    .tck_rst(tck_rst),
    .tms(tms),
    .tdi(tdi),
    .link_out(link_out),
    .core_pins_in(pins_in),
    .bsr_pins_out(pins_out),
    .test_mode(test_mode)
  );
  jtp_master master (
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(link_out.tdo),
    .tdo_oe(link_out.tdo_oe)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run is near 670 clk; ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask

  // Core side outputs cross into clk; give them time to land
  task automatic settle();
    repeat (10) @(posedge clk);
    #2;
  endtask

  task automatic t_idcode();
    master.reset_tap();
    master.scan(1'b0, 32, 99, 32'h0, got, oe);
    check(got, IDCODE_VAL, "id scan");
    check({31'h0, oe}, 32'h1, "oe in shift");
    $display("test idcode done");
  endtask

  task automatic t_sample();
    master.scan(1'b1, 3, 99, {29'h0, INS_SAMPLE}, got, oe);
    check(got, {29'h0, IR_CAPTURE_VAL}, "ir capture");
    check({31'h0, oe}, 32'h1, "oe in ir shift");
    master.scan(1'b0, 8, 99, 32'h3c, got, oe);
    check(got, 32'ha5, "pin capture");
    settle();
    check({24'h0, pins_out}, 32'h3c, "preload out");
    check({31'h0, test_mode}, 32'h0, "mode off");
    $display("test sample done");
  endtask

  task automatic t_extest_pause();
    master.scan(1'b1, 3, 99, {29'h0, INS_EXTEST}, got, oe);
    settle();
    check({31'h0, test_mode}, 32'h1, "mode on");
    check({24'h0, pins_out}, 32'h3c, "out held");
    master.scan(1'b0, 8, 3, 32'h96, got, oe);
    check({31'h0, oe}, 32'h1, "oe off in pause");
    settle();
    check({24'h0, pins_out}, 32'h96, "paused load");
    $display("test extest pause done");
  endtask

  task automatic t_select_ir_exit();
    master.step(1'b1, 1'b0);
    master.step(1'b1, 1'b0);
    master.step(1'b1, 1'b0);
    master.step(1'b0, 1'b0);
    settle();
    check({31'h0, test_mode}, 32'h0, "mode after exit");
    master.scan(1'b0, 32, 99, 32'h0, got, oe);
    check(got, IDCODE_VAL, "id after exit");
    $display("test select ir exit done");
  endtask

  // Reset held over two link edges so no stale value meets an assertion
  task automatic t_bypass_reset();
    master.scan(1'b1, 3, 99, {29'h0, INS_BYPASS}, got, oe);
    master.scan(1'b0, 3, 99, 32'h1, got, oe);
    check(got, 32'h4, "bypass delay");
    tck_rst = 1'b1;
    repeat (2) master.step(1'b1, 1'b0);
    #2 tck_rst = 1'b0;
    master.step(1'b0, 1'b0);
    master.scan(1'b0, 32, 99, 32'h0, got, oe);
    check(got, IDCODE_VAL, "id after tap reset");
    $display("test bypass reset done");
  endtask

  initial begin
    sys_rst = 1'b1;
    tck_rst = 1'b1;
    pins_in = 8'ha5;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    #2 sys_rst = 1'b0;
    repeat (2) master.step(1'b1, 1'b0);
    #2 tck_rst = 1'b0;
    t_idcode();
    t_sample();
    t_extest_pause();
    t_select_ir_exit();
    t_bypass_reset();
    stop_test();
  end
endmodule
